// [rtl/cki_pkg.sv]
// Purpose: Shared constants and types for the clock unit interrupt register
// Assumes: 32-bit APB, one register word at byte offset 0x08
// Notes: Bit positions, reset value and decode constants live here
package cki_pkg;
  // Register map
  localparam logic [11:0] CKI_INT_OFFSET = 12'h008;
  localparam logic [31:0] CKI_INT_RESET = 32'h00000000;
  // Number of stabilization sources
  localparam int CKI_NSRC = 6;
  // Field positions (low bit of each six-bit group, plus the single stuck flag and stuck clear bits)
  localparam int CKI_FLAG_LSB = 0;
  localparam int CKI_STUCK_FLAG_BIT = 7;
  localparam int CKI_EN_LSB = 8;
  localparam int CKI_CLR_LSB = 16;
  localparam int CKI_STUCK_CLR_BIT = 23;
  // Source order inside every six-bit group
  localparam int CKI_SRC_RC40K = 0;
  localparam int CKI_SRC_SLOW_XTAL = 1;
  localparam int CKI_SRC_RC8 = 2;
  localparam int CKI_SRC_FAST_XTAL = 3;
  localparam int CKI_SRC_LOOP = 4;
  localparam int CKI_SRC_RC28 = 5;
  // Stuck detector: pclk cycles without an edge before declaring stuck
  localparam logic [7:0] CKI_STUCK_LIMIT = 8'h40;
  localparam logic [7:0] CKI_STUCK_CNT_RESET = 8'h00;
  // Source status from the analog side
  typedef struct packed {
    logic [CKI_NSRC-1:0] stable;
    logic fast_xtal_clk;
  } cki_osc_status_t;
endpackage : cki_pkg

// [rtl/cki_irq_flags.sv]
// Purpose: Interrupt register of the clock unit: flags, enables, clears
// Assumes: APB slave on pclk; oscillator status is asynchronous to pclk
// Notes: Zero wait states; pslverr for unmapped addresses
// How it works
// - Write one bit 23 clears stuck flag
// - Write one bit 21 clears rc28 flag
// - Write one bit 20 clears loop flag
// - Write one bit 19 clears fast crystal flag
// - Write one bit 18 clears rc8 flag
// - Write one bit 17 clears slow crystal flag
// - Write one bit 16 clears rc40k flag
// - Writing zero to clear bit changes nothing
// - Bit 13 enables rc28 stable interrupt
// - Bit 12 enables loop stable interrupt
// - Bit 11 enables fast crystal stable interrupt
// - Register at 0x08, resets to zero
// - Stable and enabled sets sticky flag
// - Stopped fast crystal sets stuck flag
// - Bit 8 enables rc40k stable interrupt
//
// Chosen here: the APB slave port.
module cki_irq_flags (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator status, asynchronous
  input wire cki_pkg::cki_osc_status_t osc_status,
  // Interrupt to the core
  output logic clk_irq
);

  // Synchronisers for stable levels and the fast crystal clock
  logic [cki_pkg::CKI_NSRC:0] sync1_ff;
  logic [cki_pkg::CKI_NSRC:0] sync2_ff;
  // Previous sampled crystal clock for edge detect
  logic xtal_prev_ff;
  // Cycles since the last crystal edge
  logic [7:0] stuck_cnt_ff;
  logic [7:0] nxt_stuck_cnt;
  // Stored state
  logic [cki_pkg::CKI_NSRC-1:0] flag_ff;
  logic [cki_pkg::CKI_NSRC-1:0] en_ff;
  logic stuck_flag_ff;
  logic [cki_pkg::CKI_NSRC-1:0] nxt_flag;
  logic [cki_pkg::CKI_NSRC-1:0] nxt_en;
  logic nxt_stuck_flag;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // Decode
  wire hit = (paddr == cki_pkg::CKI_INT_OFFSET);
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && hit;
  wire [cki_pkg::CKI_NSRC-1:0] stable_s = sync2_ff[cki_pkg::CKI_NSRC-1:0];
  wire xtal_s = sync2_ff[cki_pkg::CKI_NSRC];
  wire xtal_edge = xtal_s ^ xtal_prev_ff;
  wire stuck_hit = (stuck_cnt_ff == cki_pkg::CKI_STUCK_LIMIT);
  // Clear masks, active only on a write access
  wire [cki_pkg::CKI_NSRC-1:0] clr_mask =
    wr_acc ? pwdata[cki_pkg::CKI_CLR_LSB +: cki_pkg::CKI_NSRC] : '0;
  wire stuck_clr = wr_acc && pwdata[cki_pkg::CKI_STUCK_CLR_BIT];
  // Set events: stable and enabled; set wins over clear
  wire [cki_pkg::CKI_NSRC-1:0] set_mask = stable_s & en_ff;
  assign nxt_flag = set_mask | (flag_ff & ~clr_mask);
  assign nxt_stuck_flag = stuck_hit | (stuck_flag_ff & ~stuck_clr);
  // Enables are plain read-write bits 13:8
  assign nxt_en = wr_acc ? pwdata[cki_pkg::CKI_EN_LSB +: cki_pkg::CKI_NSRC] : en_ff;
  // Counter saturates at the limit, restarts on any edge
  assign nxt_stuck_cnt = xtal_edge ? cki_pkg::CKI_STUCK_CNT_RESET :
                         (stuck_hit ? stuck_cnt_ff : stuck_cnt_ff + 8'h01);
  // Read image: clear bits and reserved bits read zero
  wire [31:0] rd_image = {16'h0000, 2'h0, en_ff, stuck_flag_ff, 1'b0, flag_ff};
  assign nxt_prdata = (setup && !pwrite && hit) ? rd_image : 32'h00000000;
  assign nxt_pslverr = setup && !hit;

  // Two-flop synchroniser for asynchronous status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {osc_status.fast_xtal_clk, osc_status.stable};
      sync2_ff <= sync1_ff;
    end
  end

  // Crystal activity watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_prev_ff <= 1'b0;
      stuck_cnt_ff <= cki_pkg::CKI_STUCK_CNT_RESET;
    end else begin
      xtal_prev_ff <= xtal_s;
      stuck_cnt_ff <= nxt_stuck_cnt;
    end
  end

  // Register state, all zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= '0;
      en_ff <= '0;
      stuck_flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      en_ff <= nxt_en;
      stuck_flag_ff <= nxt_stuck_flag;
    end
  end

  // APB answer: data registered in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      clk_irq <= 1'b0;
    end else begin
      prdata <= nxt_prdata;
      pready <= setup;
      pslverr <= nxt_pslverr;
      clk_irq <= (|nxt_flag) | nxt_stuck_flag;
    end
  end

  // Assertions
  clear_rc28_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[21] && !set_mask[5]) |=> !flag_ff[5])
    else $error("rc28 flag not cleared");
  clear_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[20] && !set_mask[4]) |=> !flag_ff[4])
    else $error("loop flag not cleared");
  clear_stuck_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[23] && !stuck_hit) |=> !stuck_flag_ff)
    else $error("stuck flag not cleared");
  keep_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_acc) |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff)))
    else $error("flag lost without clear");
  set_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|set_mask) |=> ((flag_ff & $past(set_mask)) == $past(set_mask)))
    else $error("enabled stable source not flagged");
  no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(|(stable_s & en_ff)) && !wr_acc) |=> (flag_ff == $past(flag_ff)))
    else $error("flag set without cause");
  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff == $past(pwdata[13:8])))
    else $error("enable bits not written");
  stuck_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    stuck_hit |=> stuck_flag_ff)
    else $error("stuck not flagged");
  read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> (prdata[31:14] == 18'h0 && prdata[6] == 1'b0))
    else $error("clear or reserved bits read non zero");
  irq_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_irq == ((|flag_ff) | stuck_flag_ff))
    else $error("irq not OR of flags");
  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
  cov_set_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(flag_ff[3]));
  cov_clr_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(flag_ff[0]));
  cov_stuck_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(stuck_flag_ff));
  cov_race_c: cover property (@(posedge pclk) disable iff (!presetn) (|(set_mask & clr_mask)));
  // Refused access seen at least once
  cov_refuse_c: cover property (@(posedge pclk) disable iff (!presetn) (setup && !hit));

  // Per-source clear checks
  // Each write-one-to-clear bit must reach its own flag only.
  // A swapped bit order in the clear mask would be caught here,
  // since each check names a fixed clear bit and a fixed flag.
  // The set event is excluded, because set wins over clear.
  clear_fxtal_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[19] && !set_mask[3]) |=> !flag_ff[3])
    else $error("fast crystal flag not cleared");
  clear_rc8_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[18] && !set_mask[2]) |=> !flag_ff[2])
    else $error("rc8 flag not cleared");
  clear_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[17] && !set_mask[1]) |=> !flag_ff[1])
    else $error("slow crystal flag not cleared");
  clear_rc40k_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[16] && !set_mask[0]) |=> !flag_ff[0])
    else $error("rc40k flag not cleared");

  // Zero in a clear bit
  // Software clears one flag with a plain word write; every other
  // clear bit is zero then, and those flags must survive the write.
  keep_on_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !pwdata[21] && flag_ff[5]) |=> flag_ff[5])
    else $error("flag lost on zero clear bit");
  keep_stuck_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !pwdata[23] && stuck_flag_ff) |=> stuck_flag_ff)
    else $error("stuck flag lost on zero clear bit");

  // Enable bits, one check per field except rc8 and slow crystal, which share one
  // The enables are ordinary read-write bits; each field is checked
  // against its own write data bit so that a shifted slice shows.
  en_rc28_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff[5] == $past(pwdata[13])))
    else $error("rc28 enable not written");
  en_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff[4] == $past(pwdata[12])))
    else $error("loop enable not written");
  en_fxtal_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff[3] == $past(pwdata[11])))
    else $error("fast crystal enable not written");
  en_rc8_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff[2:1] == $past(pwdata[10:9])))
    else $error("rc8 or slow crystal enable not written");
  en_rc40k_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> (en_ff[0] == $past(pwdata[8])))
    else $error("rc40k enable not written");
  en_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_acc |=> $stable(en_ff))
    else $error("enables changed without a write");

  // Gating of every source by its own enable
  // A stable source with its enable at zero must leave its flag low.
  // A mixed-up enable index would let a neighbour's enable through.
  gate_rc40k_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[0] && !flag_ff[0]) |=> !flag_ff[0])
    else $error("rc40k flag set while disabled");
  gate_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[1] && !flag_ff[1]) |=> !flag_ff[1])
    else $error("slow crystal flag set while disabled");
  gate_rc8_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[2] && !flag_ff[2]) |=> !flag_ff[2])
    else $error("rc8 flag set while disabled");
  gate_fxtal_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[3] && !flag_ff[3]) |=> !flag_ff[3])
    else $error("fast crystal flag set while disabled");
  gate_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[4] && !flag_ff[4]) |=> !flag_ff[4])
    else $error("loop flag set while disabled");
  gate_rc28_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!en_ff[5] && !flag_ff[5]) |=> !flag_ff[5])
    else $error("rc28 flag set while disabled");

  // Stuck detector
  // The flag is sticky: once set it only falls on a clear write.
  // The counter saturates, so it can never wrap back to zero and
  // hide a clock that stays stopped for a long time.
  stuck_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stuck_flag_ff && !stuck_clr) |=> stuck_flag_ff)
    else $error("stuck flag fell without clear");
  stuck_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    stuck_cnt_ff <= cki_pkg::CKI_STUCK_LIMIT)
    else $error("stuck counter past its limit");
  stuck_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    xtal_edge |=> (stuck_cnt_ff == cki_pkg::CKI_STUCK_CNT_RESET))
    else $error("stuck counter not restarted by an edge");

  // Read-only flags
  // Bit 7 written as one while the clock runs must not set the flag;
  // only the watchdog may raise it.
  stuck_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && pwdata[7] && !stuck_flag_ff && !stuck_hit) |=> !stuck_flag_ff)
    else $error("stuck flag set by software");

  // Reset state
  // Checked while reset is held, so no disable clause here.
  reset_zero_a: assert property (@(posedge pclk)
    !presetn |-> (flag_ff == '0 && en_ff == '0 && !stuck_flag_ff && !clk_irq))
    else $error("state not zero in reset");

  // Bus answer
  // Refused addresses answer with an error in the access cycle,
  // mapped reads return the register image, idle cycles return zero.
  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit) |=> (pslverr && pready))
    else $error("unmapped access not refused");
  slverr_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit) |=> !pslverr)
    else $error("mapped access refused");
  read_image_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> (prdata == $past(rd_image)))
    else $error("read data not the register image");
  read_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> (prdata == 32'h00000000))
    else $error("read data outside a read");
  ready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> !pready)
    else $error("ready without a setup cycle");

  // Interrupt output
  // A flag clear with no other flag set must drop the line next edge.
  irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(|nxt_flag) && !nxt_stuck_flag) |=> !clk_irq)
    else $error("irq held with no flag");

endmodule : cki_irq_flags

// [verif/cki_irq_flags_bench.sv]
// Purpose: Self-checking bench for the clock unit interrupt register
// Assumes: Zero-wait APB slave, flags follow synced stable inputs
// Notes: Bench toggles the fast crystal clock unless a scenario stops it
module cki_irq_flags_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, clk_irq, err;
  logic xtal_run = 1'b1; // Fast crystal clock running
  cki_pkg::cki_osc_status_t osc = '0;
  int fail_count = 0, num_checks = 0;
  cki_irq_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_status(osc), .clk_irq(clk_irq));
  always #2 pclk = ~pclk;
  // Fast crystal clock stand-in, one toggle per pclk
  always @(posedge pclk) if (xtal_run) osc.fast_xtal_clk <= ~osc.fast_xtal_clk;
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Enables gate flags; flags and clear bits read as specified
  task automatic t_enable;
    apb(0, 12'h008, 32'h0); chk("reset", 32'h00000000, rd);
    osc.stable <= 6'h3F;
    repeat (8) @(posedge pclk);
    apb(0, 12'h008, 32'h0); chk("gated", 32'h00000000, rd);
    apb(1, 12'h008, 32'h00003FBF);
    repeat (6) @(posedge pclk);
    apb(0, 12'h008, 32'h0); chk("set", 32'h00003F3F, rd);
    chk("irq", 32'h1, {31'h0, clk_irq});
  endtask : t_enable
  // Clear one flag at a time, others stay
  task automatic t_clear;
    osc.stable <= 6'h00;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h008, 32'h00003F00 | (32'h00010000 << i));
      apb(0, 12'h008, 32'h0); chk("clear", 32'h00003F00 | ((32'h3F << (i + 1)) & 32'h3F), rd);
    end
    chk("irq_off", 32'h0, {31'h0, clk_irq});
  endtask : t_clear
  // Unmapped address refused, register untouched
  task automatic t_unmapped;
    apb(1, 12'h00C, 32'h00000000); chk("err_w", 32'h1, {31'h0, err});
    apb(0, 12'h00C, 32'h0); chk("err_r", 32'h1, {31'h0, err});
    apb(0, 12'h008, 32'h0); chk("kept", 32'h00003F00, rd);
  endtask : t_unmapped
  // Stopped crystal sets stuck flag; clear once running
  task automatic t_stuck;
    xtal_run <= 1'b0;
    repeat (80) @(posedge pclk);
    apb(0, 12'h008, 32'h0); chk("stuck", 32'h00003F80, rd);
    chk("irq_stuck", 32'h1, {31'h0, clk_irq});
    xtal_run <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1, 12'h008, 32'h00803F00);
    apb(0, 12'h008, 32'h0); chk("unstuck", 32'h00003F00, rd);
  endtask : t_stuck
  // Single enables gate single sources; flags stay sticky
  task automatic t_gate;
    apb(1, 12'h008, 32'h00001100);
    osc.stable <= 6'h3F;
    repeat (8) @(posedge pclk);
    apb(0, 12'h008, 32'h0); chk("gate_a", 32'h00001111, rd);
    apb(1, 12'h008, 32'h00000800);
    repeat (6) @(posedge pclk);
    apb(0, 12'h008, 32'h0); chk("gate_b", 32'h00000819, rd);
  endtask : t_gate
  // Verdict and end of run
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_enable();
    t_clear();
    t_unmapped();
    t_stuck();
    t_gate();
    end_of_test();
  end
  // Watchdog
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule : cki_irq_flags_bench
